/* design/tfb_consts.svh */
`ifndef TFB_CONSTS_SVH
`define TFB_CONSTS_SVH
`define TFB_REG_CTRL 8'h00
`define TFB_REG_STATUS 8'h04
`define TFB_REG_TILE 8'h08
`define TFB_REG_MASK 8'h0C
`define TFB_REG_XFER 8'h10
`define TFB_REG_QUAD 8'h14
`define TFB_REG_DATA_LAST 8'h7C
`define TFB_DATA_PAGE 2'h1
`define TFB_CTRL_DEPTH 0
`define TFB_CTRL_RES 1
`define TFB_CTRL_SWAP 2
`define TFB_TILE_SHAPE 12
`define TFB_TILE_WRITE 13
`define TFB_XFER_RT 12
`define TFB_MASK_RST 32'hFFFFFFFF
`define TFB_HALF_LO 32'h0000FFFF
`define TFB_BANK_DEPTH 256
`define TFB_RESP_OKAY 2'h0
`define TFB_RESP_SLVERR 2'h2
`endif

/* design/tfb_pkg.sv */
`include "tfb_consts.svh"
`default_nettype none
package tfb_pkg;
  typedef enum logic {SHAPE_ROW, SHAPE_SQUARE} tfb_shape_type;
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } tfb_wr_type;
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
  } tfb_rd_type;
  typedef struct packed {
    logic [7:0] addr;
    logic [3:0] idx;
  } tfb_slot_type;

  function automatic logic tfb_mapped(input logic [7:0] a);
    return (a <= `TFB_REG_QUAD) || (a[7:6] == `TFB_DATA_PAGE);
  endfunction
endpackage
`default_nettype wire

/* design/tfb_axil.sv */
`timescale 1ns/1ns
`default_nettype none
`include "tfb_consts.svh"
module tfb_axil
  import tfb_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output tfb_wr_type wr,
  output tfb_rd_type rd,
  input wire logic [31:0] rdata
);
  logic aw_have_r, w_have_r, ar_have_r;
  logic awready_r, wready_r, arready_r, bvalid_r, rvalid_r;
  logic [7:0] aw_addr_r, ar_addr_r;
  logic [31:0] w_data_r, rdata_r;
  logic [3:0] w_strb_r;
  logic [1:0] bresp_r, rresp_r;
  logic wr_fire, rd_fire;
  logic aw_have_nxt, w_have_nxt, ar_have_nxt, bvalid_nxt, rvalid_nxt;

  always_comb begin
    wr_fire = aw_have_r && w_have_r && !bvalid_r;
    rd_fire = ar_have_r && !rvalid_r;
    aw_have_nxt = (aw_have_r && !wr_fire) || (s_axi_awvalid && awready_r);
    w_have_nxt = (w_have_r && !wr_fire) || (s_axi_wvalid && wready_r);
    ar_have_nxt = (ar_have_r && !rd_fire) || (s_axi_arvalid && arready_r);
    bvalid_nxt = (bvalid_r && !s_axi_bready) || wr_fire;
    rvalid_nxt = (rvalid_r && !s_axi_rready) || rd_fire;
  end

  // Ready is withheld while a response waits, so one write and one read at most are in flight.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      ar_have_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      arready_r <= 1'b0;
      bvalid_r <= 1'b0;
      rvalid_r <= 1'b0;
    end else begin
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      ar_have_r <= ar_have_nxt;
      awready_r <= !aw_have_nxt && !bvalid_nxt;
      wready_r <= !w_have_nxt && !bvalid_nxt;
      arready_r <= !ar_have_nxt && !rvalid_nxt;
      bvalid_r <= bvalid_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      aw_addr_r <= 8'h00;
      ar_addr_r <= 8'h00;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      bresp_r <= `TFB_RESP_OKAY;
      rresp_r <= `TFB_RESP_OKAY;
      rdata_r <= 32'h00000000;
    end else begin
      if (s_axi_awvalid && awready_r) aw_addr_r <= {s_axi_awaddr[7:2], 2'h0};
      if (s_axi_arvalid && arready_r) ar_addr_r <= {s_axi_araddr[7:2], 2'h0};
      if (s_axi_wvalid && wready_r) begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire) bresp_r <= tfb_mapped(aw_addr_r) ? `TFB_RESP_OKAY : `TFB_RESP_SLVERR;
      if (rd_fire) begin
        rdata_r <= rdata;
        rresp_r <= tfb_mapped(ar_addr_r) ? `TFB_RESP_OKAY : `TFB_RESP_SLVERR;
      end
    end
  end

  assign wr = '{valid: wr_fire, addr: aw_addr_r, data: w_data_r, strb: w_strb_r};
  assign rd = '{valid: rd_fire, addr: ar_addr_r};
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_arready = arready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
endmodule
`default_nettype wire

/* design/tfb_frame_buffer.sv */
// Summary of operation
// - Sixteen lines, four independently addressed groups.
// - Sixteen adjacent pixels use distinct lines.
// - Each 4x4 square uses distinct lines.
// - Row tile: one address to all groups.
// - Square tile: base plus 0..3 strides.
// - Tiles sit on four-pixel boundaries.
// - Swap exchanges display and update buffers; with both splits on, only the depth halves swap.
// - Depth split: one 32-bit or two 16-bit.
// - Quadrants act as independent buffers.
// - Update port reads/writes like plain memory.
// - Load at line start, shift per pixel.
// - One access loads whole 512-bit register.
// - Per-bit write mask, no longer cycle.
// - Reload while shifting continues.
// - Shifting starts at supplied start pointer.
`timescale 1ns/1ns
`default_nettype none
`include "tfb_consts.svh"
module tfb_frame_buffer
  import tfb_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serial_clk_pin,
  input wire logic line_start_pin,
  input wire logic vblank_pin,
  output logic [31:0] pixel_out,
  output logic pixel_valid
);
  tfb_wr_type wr;
  tfb_rd_type rd;
  logic [31:0] rdata;

  tfb_axil i_tfb_axil (
    .core_clk(core_clk), .rst(rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .wr(wr), .rd(rd), .rdata(rdata)
  );

  // Each bank is one data line; banks 4g..4g+3 form group g and share an address.
  logic [31:0] mem [16][`TFB_BANK_DEPTH];
  logic [31:0] tile_data_r [16];
  logic [31:0] ser_row_r [16];
  logic [31:0] mask_r, pixel_r;
  logic depth_split_r, res_split_r, swap_pend_r, disp_half_r;
  logic [1:0] disp_quad_r, upd_quad_r;
  logic [5:0] tile_x_r, tile_y_r;
  tfb_shape_type shape_r;
  logic tile_wr_r, op_pend_r, pixel_valid_r;
  logic [7:0] xfer_row_r;
  logic [3:0] xfer_start_r, ser_ptr_r;
  logic xfer_rt_r, xfer_arm_r;
  logic [2:0] sclk_s_r, line_s_r, vbl_s_r;
  logic sc_rise, line_rise, vb_rise, load_now, op_go, upd_half;
  logic [5:0] ux, uy;
  logic [7:0] ser_addr;
  logic [31:0] eff_mask;
  tfb_slot_type slot [16];

  function automatic tfb_slot_type tfb_map(input logic [3:0] bank, input logic [5:0] x,
                                           input logic [5:0] y, input tfb_shape_type shape);
    tfb_slot_type s;
    logic [1:0] r;
    logic [5:0] row;
    r = (shape == SHAPE_ROW) ? bank[3:2] - y[1:0] : bank[3:2] - x[3:2] - y[1:0];
    row = (shape == SHAPE_ROW) ? y : y + {4'h0, r};
    s.addr = {row, x[5:4]};
    s.idx = {r, bank[1:0]};
    return s;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old & ~m) | (nw & m);
  endfunction

  // In depth-split mode only one 16-bit half is visible, always in the low bits.
  function automatic logic [31:0] pick(input logic [31:0] w, input logic split, input logic half);
    if (!split) return w;
    return half ? {16'h0000, w[31:16]} : {16'h0000, w[15:0]};
  endfunction

  // Pin inputs cross into core_clk; stage 2 only serves edge detection.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sclk_s_r <= 3'h0;
      line_s_r <= 3'h0;
      vbl_s_r <= 3'h0;
    end else begin
      sclk_s_r <= {sclk_s_r[1:0], serial_clk_pin};
      line_s_r <= {line_s_r[1:0], line_start_pin};
      vbl_s_r <= {vbl_s_r[1:0], vblank_pin};
    end
  end

  always_comb begin
    sc_rise = sclk_s_r[1] && !sclk_s_r[2];
    line_rise = line_s_r[1] && !line_s_r[2];
    vb_rise = vbl_s_r[1] && !vbl_s_r[2];
    load_now = xfer_arm_r && (xfer_rt_r || line_rise);
    op_go = op_pend_r && !load_now;
    upd_half = !disp_half_r;
    eff_mask = mask_r;
    if (depth_split_r) eff_mask = mask_r & (upd_half ? ~`TFB_HALF_LO : `TFB_HALF_LO);
    ux = tile_x_r;
    uy = tile_y_r;
    ser_addr = xfer_row_r;
    if (res_split_r) begin
      ux = {upd_quad_r[0], tile_x_r[4:0]};
      uy = {upd_quad_r[1], tile_y_r[4:0]};
      ser_addr = {disp_quad_r[1], xfer_row_r[6:2], disp_quad_r[0], xfer_row_r[0]};
    end
    for (int b = 0; b < 16; b++) slot[b] = tfb_map(4'(b), ux, uy, shape_r);
  end

  // Masked write completes in the same single cycle as a plain write.
  always_ff @(posedge core_clk) begin
    if (op_go && tile_wr_r) begin
      for (int b = 0; b < 16; b++) begin
        mem[b][slot[b].addr] <= (mem[b][slot[b].addr] & ~eff_mask) |
          ((depth_split_r ? {2{tile_data_r[slot[b].idx][15:0]}} : tile_data_r[slot[b].idx]) & eff_mask);
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 16; i++) tile_data_r[i] <= 32'h00000000;
      mask_r <= `TFB_MASK_RST;
    end else begin
      if (wr.valid && wr.addr[7:6] == `TFB_DATA_PAGE) begin
        tile_data_r[wr.addr[5:2]] <= merge(tile_data_r[wr.addr[5:2]], wr.data, wr.strb);
      end
      if (wr.valid && wr.addr == `TFB_REG_MASK) mask_r <= merge(mask_r, wr.data, wr.strb);
      if (op_go && !tile_wr_r) begin
        for (int b = 0; b < 16; b++) begin
          tile_data_r[slot[b].idx] <= pick(mem[b][slot[b].addr], depth_split_r, upd_half);
        end
      end
    end
  end

  // A new command that lands as the old one runs stays pending for the next cycle.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tile_x_r <= 6'h00;
      tile_y_r <= 6'h00;
      shape_r <= SHAPE_ROW;
      tile_wr_r <= 1'b0;
      op_pend_r <= 1'b0;
    end else begin
      if (op_go) op_pend_r <= 1'b0;
      if (wr.valid && wr.addr == `TFB_REG_TILE) begin
        shape_r <= wr.data[`TFB_TILE_SHAPE] ? SHAPE_SQUARE : SHAPE_ROW;
        tile_x_r <= wr.data[`TFB_TILE_SHAPE] ? {wr.data[5:2], 2'h0} : {wr.data[5:4], 4'h0};
        tile_y_r <= wr.data[11:6];
        tile_wr_r <= wr.data[`TFB_TILE_WRITE];
        op_pend_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      depth_split_r <= 1'b0;
      res_split_r <= 1'b0;
      swap_pend_r <= 1'b0;
      disp_half_r <= 1'b0;
      disp_quad_r <= 2'h0;
      upd_quad_r <= 2'h1;
    end else begin
      if (wr.valid && wr.addr == `TFB_REG_QUAD) begin
        disp_quad_r <= wr.data[1:0];
        upd_quad_r <= wr.data[3:2];
      end
      if (vb_rise && swap_pend_r) begin
        swap_pend_r <= 1'b0;
        if (depth_split_r) begin
          disp_half_r <= !disp_half_r;
        end else if (res_split_r) begin
          disp_quad_r <= upd_quad_r;
          upd_quad_r <= disp_quad_r;
        end
      end
      if (wr.valid && wr.addr == `TFB_REG_CTRL) begin
        depth_split_r <= wr.data[`TFB_CTRL_DEPTH];
        res_split_r <= wr.data[`TFB_CTRL_RES];
        if (wr.data[`TFB_CTRL_SWAP]) swap_pend_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      xfer_row_r <= 8'h00;
      xfer_start_r <= 4'h0;
      xfer_rt_r <= 1'b0;
      xfer_arm_r <= 1'b0;
    end else begin
      if (load_now) xfer_arm_r <= 1'b0;
      if (wr.valid && wr.addr == `TFB_REG_XFER) begin
        xfer_row_r <= wr.data[7:0];
        xfer_start_r <= wr.data[11:8];
        xfer_rt_r <= wr.data[`TFB_XFER_RT];
        xfer_arm_r <= 1'b1;
      end
    end
  end

  // All sixteen banks are read at one address, filling 512 bits at once.
  always_ff @(posedge core_clk) begin
    if (load_now) begin
      for (int i = 0; i < 16; i++) begin
        ser_row_r[i] <= mem[{i[3:2] + ser_addr[3:2], i[1:0]}][ser_addr];
      end
    end
  end

  // The pixel due on a load cycle still comes from the old row, so shifting never stalls.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ser_ptr_r <= 4'h0;
      pixel_r <= 32'h00000000;
      pixel_valid_r <= 1'b0;
    end else begin
      pixel_valid_r <= sc_rise;
      if (sc_rise) begin
        pixel_r <= pick(ser_row_r[ser_ptr_r], depth_split_r, disp_half_r);
        ser_ptr_r <= ser_ptr_r + 4'h1;
      end
      if (load_now) ser_ptr_r <= xfer_start_r;
    end
  end

  always_comb begin
    rdata = 32'h00000000;
    case (rd.addr)
      `TFB_REG_CTRL: rdata = {30'h0, res_split_r, depth_split_r};
      `TFB_REG_STATUS: rdata = {24'h0, upd_quad_r, disp_quad_r, xfer_arm_r, op_pend_r, swap_pend_r, disp_half_r};
      `TFB_REG_TILE: rdata = {18'h0, tile_wr_r, shape_r == SHAPE_SQUARE, tile_y_r, tile_x_r};
      `TFB_REG_MASK: rdata = mask_r;
      `TFB_REG_XFER: rdata = {19'h0, xfer_rt_r, xfer_start_r, xfer_row_r};
      `TFB_REG_QUAD: rdata = {28'h0, upd_quad_r, disp_quad_r};
      default: if (rd.addr[7:6] == `TFB_DATA_PAGE) rdata = tile_data_r[rd.addr[5:2]];
    endcase
  end

  assign pixel_out = pixel_r;
  assign pixel_valid = pixel_valid_r;

  logic [15:0] idx_cover;
  logic [7:0] a0;
  logic [31:0] old0;
  always_comb begin
    idx_cover = 16'h0000;
    for (int b = 0; b < 16; b++) idx_cover[slot[b].idx] = 1'b1;
    a0 = slot[0].addr;
    old0 = mem[0][a0];
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_lines_distinct: assert property (op_pend_r |-> idx_cover == 16'hFFFF)
    else $error("tile maps two pixels onto one data line");
  a_row_same_addr: assert property (
    op_go && shape_r == SHAPE_ROW |-> slot[0].addr == slot[4].addr && slot[8].addr == slot[12].addr)
    else $error("row tile groups got different addresses");
  a_group_shares: assert property (
    op_go && shape_r == SHAPE_SQUARE |-> slot[4].addr == slot[7].addr && slot[0].addr != slot[4].addr)
    else $error("square tile group addressing wrong");
  a_swap_retrace: assert property ($changed(disp_half_r) |-> $past(vb_rise) && $past(swap_pend_r))
    else $error("display half changed outside retrace");
  a_op_not_starved: assert property (op_pend_r && !load_now |=> !op_pend_r || $past(wr.valid))
    else $error("update access stalled without a reload");
  a_load_start: assert property (load_now |=> ser_ptr_r == $past(xfer_start_r) && !xfer_arm_r)
    else $error("serial pointer not set to start position");
  a_shift_step: assert property (sc_rise && !load_now |=> pixel_valid_r && ser_ptr_r == $past(ser_ptr_r) + 4'h1)
    else $error("serial shift did not advance");
  a_mask_keep: assert property (
    op_go && tile_wr_r |=> ((mem[0][$past(a0)] ^ $past(old0)) & ~$past(eff_mask)) == 32'h0)
    else $error("write touched masked bits");
endmodule
`default_nettype wire

/* dv/tfb_video_gen.sv */
`timescale 1ns/1ns
`default_nettype none
module tfb_video_gen (
  input wire logic core_clk,
  output logic serial_clk_pin,
  output logic line_start_pin,
  output logic vblank_pin
);
  // The shift clock stands still low outside the bursts that the bench asks for.
  initial begin
    serial_clk_pin = 1'b0;
    line_start_pin = 1'b0;
    vblank_pin = 1'b0;
  end

  // Two core cycles high and two low give 25 MHz, below the shift-rate ceiling.
  task automatic shift_pixels(input int n);
    repeat (n) begin
      repeat (2) @(posedge core_clk);
      serial_clk_pin <= 1'b1;
      repeat (2) @(posedge core_clk);
      serial_clk_pin <= 1'b0;
    end
    repeat (5) @(posedge core_clk);
  endtask

  task automatic line_start();
    @(posedge core_clk);
    line_start_pin <= 1'b1;
    repeat (3) @(posedge core_clk);
    line_start_pin <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask

  task automatic vertical_retrace();
    @(posedge core_clk);
    vblank_pin <= 1'b1;
    repeat (3) @(posedge core_clk);
    vblank_pin <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

/* dv/tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "tfb_consts.svh"
module tb;
  logic core_clk, rst;
  logic [7:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid, pixel_valid;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, pixel_out, rd_val;
  logic serial_clk_pin, line_start_pin, vblank_pin;
  logic [31:0] pix_q[$];
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;

  tfb_frame_buffer i_tfb_frame_buffer (.core_clk(core_clk), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .serial_clk_pin(serial_clk_pin), .line_start_pin(line_start_pin), .vblank_pin(vblank_pin),
    .pixel_out(pixel_out), .pixel_valid(pixel_valid));

  tfb_video_gen i_tfb_video_gen (.core_clk(core_clk), .serial_clk_pin(serial_clk_pin),
    .line_start_pin(line_start_pin), .vblank_pin(vblank_pin));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Pixels are captured mid-cycle so the one-cycle pulse is seen settled.
  always @(negedge core_clk) begin
    if (pixel_valid === 1'b1) pix_q.push_back(pixel_out);
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      conclude();
    end
  end

  task automatic conclude();
    $display("Checks made: %0d, mismatches: %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask

  // Handshakes are judged mid-cycle, where the values equal those at the next rising edge.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic aw_t, w_t, b_t;
    @(posedge core_clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_t = 1'b0;
    while (b_t !== 1'b1) begin
      @(negedge core_clk);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      b_t = bvalid && bready;
      resp = bresp;
      @(posedge core_clk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      if (b_t) bready <= 1'b0;
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic ar_t, r_t;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_t = 1'b0;
    while (r_t !== 1'b1) begin
      @(negedge core_clk);
      ar_t = arvalid && arready;
      r_t = rvalid && rready;
      d = rdata;
      resp = rresp;
      @(posedge core_clk);
      if (ar_t) arvalid <= 1'b0;
      if (r_t) rready <= 1'b0;
    end
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    axi_rd(a, rd_val, rsp);
    chk(what, exp, rd_val);
  endtask

  task automatic tile_cmd(input logic [5:0] x, input logic [5:0] y, input logic sq, input logic wr);
    axi_wr(`TFB_REG_TILE, {18'h0, wr, sq, y, x}, rsp);
    do axi_rd(`TFB_REG_STATUS, rd_val, rsp);
    while (rd_val[2] !== 1'b0);
  endtask

  function automatic logic [31:0] pat(input int i);
    return 32'hA5A50000 + i * 32'h111;
  endfunction

  function automatic logic [31:0] masked(input int i);
    logic [31:0] p;
    p = pat(i);
    return {p[31:16], 16'h5678};
  endfunction

  task automatic t_reset_and_map();
    rd_chk("ctrl", `TFB_REG_CTRL, 32'h0);
    rd_chk("mask", `TFB_REG_MASK, `TFB_MASK_RST);
    rd_chk("quad", `TFB_REG_QUAD, 32'h4);
    rd_chk("unmapped_rd", 8'h20, 32'h0);
    chk("unmapped_rresp", {30'h0, `TFB_RESP_SLVERR}, {30'h0, rsp});
    axi_wr(8'h24, 32'h1234, rsp);
    chk("unmapped_bresp", {30'h0, `TFB_RESP_SLVERR}, {30'h0, rsp});
    axi_wr(8'h40, 32'h11223344, rsp);
    // A single strobe lane proves that byte writes leave the other lanes alone.
    wstrb <= 4'h2;
    axi_wr(8'h40, 32'hAABBCCDD, rsp);
    wstrb <= 4'hF;
    rd_chk("byte_write", 8'h40, 32'h1122CC44);
    chk("mapped_rresp", {30'h0, `TFB_RESP_OKAY}, {30'h0, rsp});
  endtask

  task automatic t_row_tile();
    for (int i = 0; i < 16; i++) axi_wr(8'h40 + 8'(4 * i), pat(i), rsp);
    tile_cmd(6'd16, 6'd1, 1'b0, 1'b1);
    for (int i = 0; i < 16; i++) axi_wr(8'h40 + 8'(4 * i), 32'h0, rsp);
    tile_cmd(6'd16, 6'd1, 1'b0, 1'b0);
    for (int i = 0; i < 16; i++) rd_chk("row_pixel", 8'h40 + 8'(4 * i), pat(i));
  endtask

  task automatic t_square_tile();
    for (int i = 0; i < 16; i++) axi_wr(8'h40 + 8'(4 * i), 32'h5A000000 + i, rsp);
    tile_cmd(6'd22, 6'd8, 1'b1, 1'b1);
    for (int r = 0; r < 4; r++) begin
      tile_cmd(6'd16, 6'(8 + r), 1'b0, 1'b0);
      for (int c = 0; c < 4; c++) rd_chk("square_pixel", 8'h40 + 8'(4 * (4 + c)), 32'h5A000000 + r * 4 + c);
    end
  endtask

  task automatic t_write_mask();
    axi_wr(`TFB_REG_MASK, `TFB_HALF_LO, rsp);
    for (int i = 0; i < 16; i++) axi_wr(8'h40 + 8'(4 * i), 32'h12345678, rsp);
    tile_cmd(6'd16, 6'd1, 1'b0, 1'b1);
    axi_wr(`TFB_REG_MASK, `TFB_MASK_RST, rsp);
    tile_cmd(6'd16, 6'd1, 1'b0, 1'b0);
    for (int i = 0; i < 16; i++) rd_chk("masked_pixel", 8'h40 + 8'(4 * i), masked(i));
  endtask

  task automatic t_serial();
    pix_q.delete();
    axi_wr(`TFB_REG_XFER, 32'h00001305, rsp);
    i_tfb_video_gen.shift_pixels(3);
    chk("pixel_count", 32'd3, 32'(pix_q.size()));
    for (int k = 0; k < 3; k++) chk("rt_pixel", masked(3 + k), pix_q[k]);
    pix_q.delete();
    axi_wr(`TFB_REG_XFER, 32'h00000E05, rsp);
    rd_chk("armed", `TFB_REG_STATUS, 32'h48);
    i_tfb_video_gen.shift_pixels(1);
    chk("shift_before_load", masked(6), pix_q[0]);
    i_tfb_video_gen.line_start();
    i_tfb_video_gen.shift_pixels(3);
    chk("line_count", 32'd4, 32'(pix_q.size()));
    for (int k = 0; k < 3; k++) chk("line_pixel", masked((14 + k) % 16), pix_q[1 + k]);
  endtask

  task automatic t_swap();
    axi_wr(`TFB_REG_CTRL, 32'h1, rsp);
    rd_chk("half_before", `TFB_REG_STATUS, 32'h40);
    axi_wr(`TFB_REG_CTRL, 32'h5, rsp);
    rd_chk("swap_pending", `TFB_REG_STATUS, 32'h42);
    rd_chk("ctrl_swap_reads0", `TFB_REG_CTRL, 32'h1);
    i_tfb_video_gen.vertical_retrace();
    rd_chk("swap_applied", `TFB_REG_STATUS, 32'h41);
    // The update half is now the low half, the display half the high one.
    tile_cmd(6'd16, 6'd1, 1'b0, 1'b0);
    rd_chk("depth_read", 8'h40, 32'h00005678);
    pix_q.delete();
    axi_wr(`TFB_REG_XFER, 32'h00001005, rsp);
    i_tfb_video_gen.shift_pixels(1);
    chk("depth_pixel", 32'h0000A5A5, pix_q[0]);
    axi_wr(`TFB_REG_CTRL, 32'h0, rsp);
  endtask

  // Update quadrant 1 is written, swapped onto the display and shifted out.
  task automatic t_quad_split();
    axi_wr(`TFB_REG_CTRL, 32'h2, rsp);
    for (int i = 0; i < 16; i++) axi_wr(8'h40 + 8'(4 * i), 32'hC0DE0000 + i, rsp);
    tile_cmd(6'd16, 6'd2, 1'b0, 1'b1);
    axi_wr(`TFB_REG_CTRL, 32'h6, rsp);
    i_tfb_video_gen.vertical_retrace();
    rd_chk("quad_swapped", `TFB_REG_QUAD, 32'h1);
    pix_q.delete();
    axi_wr(`TFB_REG_XFER, 32'h00001009, rsp);
    i_tfb_video_gen.shift_pixels(2);
    for (int k = 0; k < 2; k++) chk("quad_pixel", 32'hC0DE0000 + k, pix_q[k]);
    axi_wr(`TFB_REG_CTRL, 32'h0, rsp);
  endtask

  initial begin
    rst = 1'b1;
    awaddr = 8'h0;
    araddr = 8'h0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    wdata = 32'h0;
    wstrb = 4'hF;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_reset_and_map();
    t_row_tile();
    t_square_tile();
    t_write_mask();
    t_serial();
    t_swap();
    t_quad_split();
    conclude();
  end
endmodule
`default_nettype wire
